// ===== logic/tlic_top.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tlic_map.svh"


module tlic_top
  import tlic_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_pin_a_i,
  input  wire logic        ext_pin_b_i,
  input  wire logic        tmr0_ovf_i,
  input  wire logic        tmr1_ovf_i,
  input  wire logic        tmr2_ovf_i,
  input  wire logic        tmr2_ext_flag_i,
  input  wire logic        uart_rx_flag_i,
  input  wire logic        uart_tx_flag_i,
  input  wire logic [7:0]  port1_ext_irqs_i,
  input  wire logic        core_take_i,
  input  wire logic        core_reti_i,
  input  wire logic        core_idle_i,
  input  wire logic        core_pdown_i,
  output logic             irq_req_o,
  output logic [15:0]      irq_vector_o,
  output logic             irq_hi_o,
  output logic             idle_exit_o,
  output logic             wake_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  irq_enable_main_q;
  logic [7:0]  irq_priority_main_q;
  logic [7:0]  port_irq_request_flags_q;
  logic [7:0]  port_irq_enable_q;
  logic [7:0]  port_irq_polarity_q;
  logic [7:0]  port_irq_priority_q;
  logic [2:0]  evt_sts_q;
  logic [2:0]  evt_mask_q;
  logic        tmr2_clkout_en_q;
  logic        wb_ack_q;
  logic [31:0] wb_dat_q;
  logic        irq_req_q;
  logic [15:0] irq_vector_q;
  logic        irq_hi_q;
  logic        idle_exit_q;
  logic        wake_q;
  logic        irq_q;
  tlic_src_t   idx_q;
  tlic_nest_e  nest_q;

  logic [7:0]  reg_idx;
  logic        wr_en;
  logic        rd_en;
  logic        wr_lane;
  logic [7:0]  wdat;
  logic [7:0]  port_active;
  logic [7:0]  flag_d;
  logic [2:0]  evt_set;
  logic [2:0]  evt_sts_d;
  logic [31:0] rd_d;
  logic        take;
  logic        global_irq_enable;
  logic        tmr2_src;
  logic        wake_d;

  tlic_arb_if arb_bus ();

  tlic_arb u_arb (
    .a (arb_bus.arb)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Accesses complete on the edge where ack is seen by the master
  assign reg_idx = wb_adr_i[9:2];
  assign rd_en   = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q;
  assign wr_lane = wb_sel_i[0];
  assign wdat    = wb_dat_i[7:0];
  assign take    = irq_req_q && core_take_i;

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (reg_idx)
      `TLIC_IDX_IE_MAIN:   rd_d[7:0] = irq_enable_main_q;
      `TLIC_IDX_PRIO_MAIN: rd_d[7:0] = irq_priority_main_q;
      `TLIC_IDX_FLAGS:     rd_d[7:0] = port_irq_request_flags_q;
      `TLIC_IDX_PORT_EN:   rd_d[7:0] = port_irq_enable_q;
      `TLIC_IDX_POL:       rd_d[7:0] = port_irq_polarity_q;
      `TLIC_IDX_PORT_PRIO: rd_d[7:0] = port_irq_priority_q;
      `TLIC_IDX_STS:       rd_d[2:0] = evt_sts_q;
      `TLIC_IDX_MASK:      rd_d[2:0] = evt_mask_q;
      `TLIC_IDX_CTRL:      rd_d[0]   = tmr2_clkout_en_q;
      `TLIC_IDX_STATE:     rd_d[8:0] = {nest_q, idx_q, irq_req_q};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_q <= rd_en;
      if (rd_en) begin
        wb_dat_q <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // reset clears all registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable_main_q   <= `TLIC_RST_REG;
      irq_priority_main_q <= `TLIC_RST_REG;
      port_irq_enable_q   <= `TLIC_RST_REG;
      port_irq_polarity_q <= `TLIC_RST_REG;
      port_irq_priority_q <= `TLIC_RST_REG;
      evt_mask_q          <= `TLIC_RST_EVT;
      tmr2_clkout_en_q    <= 1'b0;
    end else if (ce_i && wr_en && wr_lane) begin
      unique case (reg_idx)
        `TLIC_IDX_IE_MAIN:   irq_enable_main_q   <= wdat;
        `TLIC_IDX_PRIO_MAIN: irq_priority_main_q <= wdat;
        `TLIC_IDX_PORT_EN:   port_irq_enable_q   <= wdat;
        `TLIC_IDX_POL:       port_irq_polarity_q <= wdat;
        `TLIC_IDX_PORT_PRIO: port_irq_priority_q <= wdat;
        `TLIC_IDX_MASK:      evt_mask_q          <= wdat[2:0];
        `TLIC_IDX_CTRL:      tmr2_clkout_en_q    <= wdat[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port request flags
  // ----------------------------------------------------------------
  // pin n feeds port interrupt n+2; polarity 1 = high
  assign port_active = ~(port1_ext_irqs_i ^ port_irq_polarity_q);

  always_comb begin
    flag_d = port_irq_request_flags_q;
    if (wr_en && wr_lane && reg_idx == `TLIC_IDX_FLAGS) begin
      flag_d = wdat;
    end
    // active level sets flag; set beats a clearing write
    flag_d = flag_d | port_active;
  end

  // no clear on vectoring; only software writes clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_irq_request_flags_q <= `TLIC_RST_REG;
    end else if (ce_i) begin
      port_irq_request_flags_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Source gathering
  // ----------------------------------------------------------------
  assign global_irq_enable = irq_enable_main_q[`TLIC_BIT_GLOBAL];
  // roll-overs ignored in clock-out mode, external flag kept
  assign tmr2_src = (tmr2_ovf_i && !tmr2_clkout_en_q) || tmr2_ext_flag_i;

  always_comb begin
    logic [7:0] pr;
    logic [7:0] pe;
    logic [7:0] pp;
    logic [7:0] ce;
    logic [7:0] cp;
    pr = port_irq_request_flags_q & port_irq_enable_q;
    pe = port_irq_priority_q;
    ce = irq_enable_main_q;
    cp = irq_priority_main_q;
    pp = pr;
    // rank order: ext0 uart p5 t0 p6 ext1 p2 p7 t1 t2 p3 p8 p4 p9
    arb_bus.req = {pp[7], pp[2], pp[6], pp[1],
                   tmr2_src && ce[`TLIC_BIT_TMR2],
                   tmr1_ovf_i && ce[`TLIC_BIT_TMR1],
                   pp[5], pp[0],
                   ext_pin_b_i && ce[`TLIC_BIT_XPIN1],
                   pp[4],
                   tmr0_ovf_i && ce[`TLIC_BIT_TMR0],
                   pp[3],
                   (uart_rx_flag_i || uart_tx_flag_i) && ce[`TLIC_BIT_UART],
                   ext_pin_a_i && ce[`TLIC_BIT_XPIN0]};
    arb_bus.hi  = {pe[7], pe[2], pe[6], pe[1],
                   cp[`TLIC_BIT_TMR2], cp[`TLIC_BIT_TMR1],
                   pe[5], pe[0], cp[`TLIC_BIT_XPIN1], pe[4],
                   cp[`TLIC_BIT_TMR0], pe[3], cp[`TLIC_BIT_UART],
                   cp[`TLIC_BIT_XPIN0]};
    if (!global_irq_enable) begin
      arb_bus.req = 14'h0000;
    end
    // high level open unless a high routine runs
    arb_bus.allow_hi = (nest_q == TLIC_NONE) || (nest_q == TLIC_LO);
    arb_bus.allow_lo = (nest_q == TLIC_NONE);
  end

  // ----------------------------------------------------------------
  // Vector hand-off and nesting
  // ----------------------------------------------------------------
  // Request drops for one cycle after a take so the next pick sees
  // the updated nesting state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_req_q    <= 1'b0;
      irq_vector_q <= 16'h0000;
      irq_hi_q     <= 1'b0;
      idx_q        <= 4'h0;
    end else if (ce_i) begin
      // vector offered until the core takes it
      irq_req_q    <= arb_bus.valid && !take;
      irq_vector_q <= tlic_vector(arb_bus.idx);
      irq_hi_q     <= arb_bus.is_hi;
      idx_q        <= arb_bus.idx;
    end
  end

  // A take in the same cycle as a return wins; the return is lost
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nest_q <= TLIC_NONE;
    end else if (ce_i) begin
      unique case (nest_q)
        TLIC_NONE: begin
          if (take) begin
            nest_q <= irq_hi_q ? TLIC_HI : TLIC_LO;
          end
        end
        TLIC_LO: begin
          if (take && irq_hi_q) begin
            nest_q <= TLIC_LO_HI;
          end else if (core_reti_i && !take) begin
            nest_q <= TLIC_NONE;
          end
        end
        TLIC_HI: begin
          if (core_reti_i) begin
            nest_q <= TLIC_NONE;
          end
        end
        TLIC_LO_HI: begin
          if (core_reti_i) begin
            nest_q <= TLIC_LO;
          end
        end
        default: nest_q <= TLIC_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power management and event interrupt
  // ----------------------------------------------------------------
  // enabled active port level wakes power-down
  assign wake_d = core_pdown_i && |(port_active & port_irq_enable_q);

  always_comb begin
    evt_set = 3'h0;
    evt_set[`TLIC_STS_TAKEN] = take;
    evt_set[`TLIC_STS_FLAG]  = |(port_active & ~port_irq_request_flags_q);
    evt_set[`TLIC_STS_WAKE]  = wake_d;
    evt_sts_d = evt_sts_q;
    if (wr_en && wr_lane && reg_idx == `TLIC_IDX_STS) begin
      evt_sts_d = evt_sts_q & ~wdat[2:0];
    end
    evt_sts_d = evt_sts_d | evt_set;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_sts_q   <= `TLIC_RST_EVT;
      irq_q       <= 1'b0;
      wake_q      <= 1'b0;
      idle_exit_q <= 1'b0;
    end else if (ce_i) begin
      evt_sts_q   <= evt_sts_d;
      irq_q       <= |(evt_sts_q & evt_mask_q);
      wake_q      <= wake_d;
      idle_exit_q <= take && core_idle_i;
    end
  end

  assign wb_ack_o     = wb_ack_q;
  assign wb_dat_o     = wb_dat_q;
  assign irq_req_o    = irq_req_q;
  assign irq_vector_o = irq_vector_q;
  assign irq_hi_o     = irq_hi_q;
  assign idle_exit_o  = idle_exit_q;
  assign wake_o       = wake_q;
  assign irq_o        = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [13:0] lvl_req;
  logic [13:0] en_rank;
  logic        sel_en;
  assign lvl_req = arb_bus.req & (arb_bus.is_hi ? arb_bus.hi : ~arb_bus.hi);
  // Enables in rank order, kept apart from the request path
  assign en_rank = {port_irq_enable_q[7], port_irq_enable_q[2],
                    port_irq_enable_q[6], port_irq_enable_q[1],
                    irq_enable_main_q[5], irq_enable_main_q[3],
                    port_irq_enable_q[5], port_irq_enable_q[0],
                    irq_enable_main_q[2], port_irq_enable_q[4],
                    irq_enable_main_q[1], port_irq_enable_q[3],
                    irq_enable_main_q[4], irq_enable_main_q[0]};
  assign sel_en  = global_irq_enable && en_rank[arb_bus.idx];

  sequence s_take;
    ce_i && irq_req_q && core_take_i;
  endsequence

  a_global_gate: assert property (
    ce_i && !global_irq_enable |=> !irq_req_q)
    else $error("request raised with global enable clear");
  a_source_enable: assert property (
    arb_bus.valid |-> sel_en)
    else $error("disabled source selected");
  a_vector_map: assert property (
    irq_req_q |-> irq_vector_o == tlic_vector(idx_q))
    else $error("vector does not match source");
  a_same_level_order: assert property (
    arb_bus.valid |->
      (lvl_req & ((14'h0001 << arb_bus.idx) - 14'h0001)) == 14'h0000)
    else $error("higher ranked request passed over");
  a_flag_set: assert property (
    ce_i && port_active != 8'h00 |=>
      (port_irq_request_flags_q & $past(port_active)) == $past(port_active))
    else $error("active port level did not set its flag");
  a_flag_sticky: assert property (
    ce_i && !(wr_en && reg_idx == `TLIC_IDX_FLAGS) |=>
      (port_irq_request_flags_q & $past(port_irq_request_flags_q))
        == $past(port_irq_request_flags_q))
    else $error("port flag cleared without a write");
  a_nest_block: assert property (
    arb_bus.valid |-> (nest_q == TLIC_NONE) ||
      (nest_q == TLIC_LO && arb_bus.is_hi))
    else $error("request allowed over equal or higher level");
  a_take_nest: assert property (
    s_take |=> !irq_req_q && nest_q != TLIC_NONE)
    else $error("take not recorded");
  a_clkout_mask: assert property (
    tmr2_clkout_en_q && !tmr2_ext_flag_i |->
      !arb_bus.req[`TLIC_SRC_TMR2])
    else $error("timer 2 roll-over in clock-out mode");
  a_wake_out: assert property (
    ce_i && wake_d |=> wake_o)
    else $error("enabled port level did not wake");

endmodule

// ===== logic/tlic_map.svh
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define TLIC_IDX_IE_MAIN   8'ha8
`define TLIC_IDX_PRIO_MAIN 8'hb8
`define TLIC_IDX_FLAGS     8'hc0
`define TLIC_IDX_PORT_EN   8'he8
`define TLIC_IDX_POL       8'he9
`define TLIC_IDX_PORT_PRIO 8'hf8
`define TLIC_IDX_STS       8'h10
`define TLIC_IDX_MASK      8'h11
`define TLIC_IDX_CTRL      8'h12
`define TLIC_IDX_STATE     8'h13

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define TLIC_RST_REG       8'h00
`define TLIC_RST_EVT       3'h0
`define TLIC_BIT_GLOBAL    7
`define TLIC_BIT_TMR2      5
`define TLIC_BIT_UART      4
`define TLIC_BIT_TMR1      3
`define TLIC_BIT_XPIN1     2
`define TLIC_BIT_TMR0      1
`define TLIC_BIT_XPIN0     0
`define TLIC_BIT_CLKOUT    0
`define TLIC_STS_TAKEN     0
`define TLIC_STS_FLAG      1
`define TLIC_STS_WAKE      2

// ----------------------------------------------------------------
// Source ranks, highest first, and their vectors
// ----------------------------------------------------------------
`define TLIC_NSRC          14
`define TLIC_SRC_TMR2      4'h9
`define TLIC_VEC_XPIN0     16'h0003
`define TLIC_VEC_UART      16'h0023
`define TLIC_VEC_PORT5     16'h0053
`define TLIC_VEC_TMR0      16'h000b
`define TLIC_VEC_PORT6     16'h005b
`define TLIC_VEC_XPIN1     16'h0013
`define TLIC_VEC_PORT2     16'h003b
`define TLIC_VEC_PORT7     16'h0063
`define TLIC_VEC_TMR1      16'h001b
`define TLIC_VEC_TMR2      16'h002b
`define TLIC_VEC_PORT3     16'h0043
`define TLIC_VEC_PORT8     16'h006b
`define TLIC_VEC_PORT4     16'h004b
`define TLIC_VEC_PORT9     16'h0073

`endif

// ===== logic/tlic_pkg.sv
`include "tlic_map.svh"

package tlic_pkg;

  typedef logic [3:0]  tlic_src_t;
  typedef logic [13:0] tlic_srcvec_t;

  // Nesting of routines in service
  typedef enum logic [3:0] {
    TLIC_NONE  = 4'b0001,
    TLIC_LO    = 4'b0010,
    TLIC_HI    = 4'b0100,
    TLIC_LO_HI = 4'b1000
  } tlic_nest_e;

  function automatic logic [15:0] tlic_vector(input tlic_src_t idx);
    logic [15:0] v;
    v = `TLIC_VEC_PORT9;
    unique case (idx)
      4'h0: v = `TLIC_VEC_XPIN0;
      4'h1: v = `TLIC_VEC_UART;
      4'h2: v = `TLIC_VEC_PORT5;
      4'h3: v = `TLIC_VEC_TMR0;
      4'h4: v = `TLIC_VEC_PORT6;
      4'h5: v = `TLIC_VEC_XPIN1;
      4'h6: v = `TLIC_VEC_PORT2;
      4'h7: v = `TLIC_VEC_PORT7;
      4'h8: v = `TLIC_VEC_TMR1;
      4'h9: v = `TLIC_VEC_TMR2;
      4'ha: v = `TLIC_VEC_PORT3;
      4'hb: v = `TLIC_VEC_PORT8;
      4'hc: v = `TLIC_VEC_PORT4;
      default: v = `TLIC_VEC_PORT9;
    endcase
    return v;
  endfunction

endpackage

// ===== logic/tlic_arb_if.sv
`timescale 1ns/1ps

interface tlic_arb_if;
  import tlic_pkg::*;
  tlic_srcvec_t req;
  tlic_srcvec_t hi;
  logic         allow_hi;
  logic         allow_lo;
  logic         valid;
  tlic_src_t    idx;
  logic         is_hi;

  modport arb  (input req, hi, allow_hi, allow_lo,
                output valid, idx, is_hi);
  modport user (output req, hi, allow_hi, allow_lo,
                input valid, idx, is_hi);
endinterface

// ===== logic/tlic_arb.sv
`timescale 1ns/1ps
`include "tlic_map.svh"

module tlic_arb
  import tlic_pkg::*;
(
  tlic_arb_if.arb a
);

  // Lowest set bit wins: bit 0 is the top of the fixed ranking
  function automatic logic [4:0] first_set(input tlic_srcvec_t v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = `TLIC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [4:0] pick_hi;
  logic [4:0] pick_lo;

  // ----------------------------------------------------------------
  // Two-level choice
  // ----------------------------------------------------------------
  always_comb begin
    pick_hi = first_set(a.req & a.hi);
    pick_lo = first_set(a.req & ~a.hi);
    a.valid = 1'b0;
    a.idx   = 4'h0;
    a.is_hi = 1'b0;
    if (pick_hi[4] && a.allow_hi) begin
      a.valid = 1'b1;
      a.idx   = pick_hi[3:0];
      a.is_hi = 1'b1;
    end else if (pick_lo[4] && a.allow_lo) begin
      a.valid = 1'b1;
      a.idx   = pick_lo[3:0];
    end
  end

endmodule

// ===== verification/tlic_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Processor core side of the vector link
// ----------------------------------------------------------------
// Takes an offered vector after lag_i cycles, so that slow cores are
// covered too. The return pulse is left to the bench.
module tlic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic [3:0]  lag_i,
  input  wire logic        req_i,
  input  wire logic [15:0] vec_i,
  input  wire logic        hi_i,
  output logic             take_o,
  output logic [15:0]      vec_o,
  output logic             hi_o,
  output logic [7:0]       cnt_o
);
  logic [3:0] wait_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      take_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (take_o) begin
      take_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (en_i && req_i && wait_q >= lag_i) begin
      take_o <= 1'b1;
    end else if (req_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end

  // Record only what the controller saw accepted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_o <= 16'h0000;
      hi_o  <= 1'b0;
      cnt_o <= 8'h00;
    end else if (take_o && req_i) begin
      vec_o <= vec_i;
      hi_o  <= hi_i;
      cnt_o <= cnt_o + 8'h01;
    end
  end
endmodule

// ===== verification/tlic_top_tb.sv
`timescale 1ns/1ps

module tlic_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, pa = 1'b0, pb = 1'b0, t0 = 1'b0, t1 = 1'b0;
  logic        t2 = 1'b0, t2x = 1'b0, urx = 1'b0, utx = 1'b0;
  logic        reti = 1'b0, idle = 1'b0, pdn = 1'b0, ten = 1'b1, ce = 1'b1;
  logic        seen = 1'b0, ack, req, hi, iex, wake, irq, take, gh;
  logic [3:0]  sel = 4'h0, lag = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dw = 32'h0, rd;
  logic [7:0]  p1 = 8'hff, gcnt;
  logic [15:0] vec, gvec;
  logic [13:0] s = 14'h0;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [7:0]  ix [6] = '{8'ha8, 8'hb8, 8'he8, 8'hf8, 8'he9, 8'hc0};
  logic [15:0] vt [14] = '{16'h0003, 16'h0023, 16'h0053, 16'h000b,
    16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b, 16'h002b,
    16'h0043, 16'h006b, 16'h004b, 16'h0073};

  tlic_top DUT (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(rd), .wb_ack_o(ack), .ext_pin_a_i(pa),
    .ext_pin_b_i(pb), .tmr0_ovf_i(t0), .tmr1_ovf_i(t1), .tmr2_ovf_i(t2),
    .tmr2_ext_flag_i(t2x), .uart_rx_flag_i(urx), .uart_tx_flag_i(utx),
    .port1_ext_irqs_i(p1), .core_take_i(take), .core_reti_i(reti),
    .core_idle_i(idle), .core_pdown_i(pdn), .irq_req_o(req),
    .irq_vector_o(vec), .irq_hi_o(hi), .idle_exit_o(iex),
    .wake_o(wake), .irq_o(irq));

  tlic_core_model CORE (.clk_i(clk), .rst_n_i(rst_n), .en_i(ten),
    .lag_i(lag), .req_i(req), .vec_i(vec), .hi_i(hi), .take_o(take),
    .vec_o(gvec), .hi_o(gh), .cnt_o(gcnt));

  always #10 clk = ~clk;
  always @(posedge clk) if (iex === 1'b1) seen <= 1'b1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Port pins in rank order; pins are active low at reset polarity
  function automatic logic [7:0] pm(input logic [13:0] v);
    return {v[13], v[11], v[7], v[4], v[2], v[12], v[10], v[6]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Request held until ack is sampled high, then a one-cycle gap
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {a, 2'b00};
    dw <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    // Read data is taken at the same edge that samples ack
    q = rd;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask

  task automatic src(input logic [13:0] v);
    s = v;
    pa <= v[0];
    urx <= v[1];
    t0 <= v[3];
    pb <= v[5];
    t1 <= v[8];
    t2 <= v[9];
    p1 <= ~pm(v);
  endtask

  task automatic svc(input logic [15:0] v, input logic h);
    logic [7:0] c;
    int t;
    c = gcnt;
    t = 0;
    while (gcnt === c && t < 40) begin
      @(posedge clk);
      t++;
    end
    // A wait that runs out fails here, not on a stale vector
    chk(gcnt - c, 8'h01);
    chk(gvec, v);
    chk(gh, h);
  endtask

  task automatic quiet;
    logic [7:0] c;
    c = gcnt;
    repeat (20) @(posedge clk);
    chk(gcnt, c);
  endtask

  // Gap cycle keeps a return apart from the next take
  task automatic ret;
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({req, irq, wake, iex}, 4'h0);
    for (int i = 0; i < 6; i++) rc(ix[i], 8'h00);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        wr(ix[i], j ? 8'h5a : 8'ha5);
        rc(ix[i], j ? 8'h5a : 8'ha5);
      end
    end
    for (int i = 0; i < 4; i++) wr(ix[i], 8'h00);
    wr(8'h40, 8'hff);
    rc(8'h40, 8'h00);
    wr(8'he9, 8'h81);
    rc(8'hc0, 8'h81);
    wr(8'he9, 8'h00);
    wr(8'hc0, 8'h00);
    rc(8'hc0, 8'h00);
    wr(8'h10, 8'h07);
    wr(8'h11, 8'h01);
    src(14'h0008);
    wr(8'ha8, 8'hbd);
    quiet;
    wr(8'ha8, 8'h3f);
    quiet;
    wr(8'ha8, 8'hbf);
    svc(16'h000b, 1'b0);
    src(14'h0000);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rc(8'h10, 8'h01);
    wr(8'h10, 8'h01);
    @(posedge clk);
    chk(irq, 1'b0);
    ret;
    wr(8'he8, 8'hff);
    src(14'h3fff);
    for (int k = 0; k < 14; k++) begin
      svc(vt[k], 1'b0);
      rc(8'hc0, pm(s));
      s[k] = 1'b0;
      src(s);
      wr(8'hc0, pm(s));
      ret;
    end
    wr(8'he8, 8'hfe);
    src(14'h0040);
    quiet;
    wr(8'he8, 8'hff);
    svc(16'h003b, 1'b0);
    src(14'h0000);
    wr(8'hc0, 8'h00);
    ret;
    idle <= 1'b1;
    lag <= 4'h3;
    src(14'h0004);
    svc(16'h0053, 1'b0);
    src(14'h0000);
    ret;
    svc(16'h0053, 1'b0);
    chk(seen, 1'b1);
    wr(8'hc0, 8'h00);
    ret;
    idle <= 1'b0;
    lag <= 4'h0;
    wr(8'h12, 8'h01);
    t2 <= 1'b1;
    quiet;
    t2x <= 1'b1;
    svc(16'h002b, 1'b0);
    t2 <= 1'b0;
    t2x <= 1'b0;
    ret;
    wr(8'h12, 8'h00);
    utx <= 1'b1;
    svc(16'h0023, 1'b0);
    utx <= 1'b0;
    ret;
    wr(8'h11, 8'h04);
    wr(8'hb8, 8'h04);
    wr(8'hf8, 8'h01);
    src(14'h0008);
    svc(16'h000b, 1'b0);
    src(14'h0020);
    svc(16'h0013, 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    src(14'h0041);
    quiet;
    ret;
    svc(16'h003b, 1'b1);
    src(14'h0001);
    wr(8'hc0, 8'h00);
    ret;
    quiet;
    ret;
    svc(16'h0003, 1'b0);
    src(14'h0000);
    ret;
    ten <= 1'b0;
    wr(8'ha8, 8'h00);
    wr(8'he8, 8'h00);
    pdn <= 1'b1;
    src(14'h0040);
    repeat (3) @(posedge clk);
    chk(wake, 1'b0);
    src(14'h0000);
    wr(8'he8, 8'h01);
    // Clock enable low must freeze the wake register
    ce <= 1'b0;
    src(14'h0040);
    repeat (3) @(posedge clk);
    chk(wake, 1'b0);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk(wake, 1'b1);
    chk(irq, 1'b1);
    results;
  end
endmodule
